/* File: rtl/tscmd_cfg.svh */
// constants for the tape command interpreter: opcodes, field positions, codes
// assumes inclusion by bare name from rtl/
`ifndef TSCMD_CFG_SVH
`define TSCMD_CFG_SVH
`define TSCMD_OP_VERIFY     8'h13
`define TSCMD_OP_RECOVER    8'h14
`define TSCMD_OP_MODESEL    8'h15
`define TSCMD_OP_RESERVE    8'h16
`define TSCMD_OP_RELEASE    8'h17
`define TSCMD_OP_WFM        8'h10
`define TSCMD_OP_WRITE      8'h0a
`define TSCMD_OP_RSENSE     8'h03
`define TSCMD_BIT_FIXED     0
`define TSCMD_BIT_TPTY      4
`define TSCMD_TPID_HI       3
`define TSCMD_TPID_LO       1
`define TSCMD_BIT_BM        4
`define TSCMD_BIT_WP        7
`define TSCMD_SPD_HI        3
`define TSCMD_BLK_MIN       24'h000002
`define TSCMD_BLK_MAX       24'h010000
`define TSCMD_SK_NONE       4'h0
`define TSCMD_SK_ILLEGAL    4'h5
`define TSCMD_SK_UATTN      4'h6
`define TSCMD_ST_GOOD       8'h00
`define TSCMD_ST_CHECK      8'h02
`define TSCMD_ST_CONFLICT   8'h18
`define TSCMD_RST_SPEED     4'h0
`define TSCMD_RST_DENS      8'h02
`define TSCMD_RST_BLK       24'h000000
`endif

/* File: rtl/tscmd_pkg.sv */
// types for the tape command interpreter
// assumes tscmd_cfg.svh holds the numeric constants
`default_nettype none
package tscmd_pkg;
    typedef enum logic [2:0] {
        TSCMD_IDLE,
        TSCMD_VERIFY,
        TSCMD_RECOVER,
        TSCMD_MSEL,
        TSCMD_FLUSH,
        TSCMD_DONE
    } tscmd_state_t;
endpackage
`default_nettype wire

/* File: rtl/tscmd_core.sv */
// command execution for verify, buffered recovery, mode select and reserve
// assumes a decoded 6-byte command block and external tape and buffer engines
`timescale 1ns/1ps
`include "tscmd_cfg.svh"
`default_nettype none
module tscmd_core
    import tscmd_pkg::*;
#(
    parameter int CNT_W = 24
)(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    // command block, one-cycle start
    input  wire logic              cmd_start,
    input  wire logic [7:0]        cmd_byte0,
    input  wire logic [7:0]        cmd_byte1,
    input  wire logic [7:0]        cmd_byte2,
    input  wire logic [7:0]        cmd_byte3,
    input  wire logic [7:0]        cmd_byte4,
    input  wire logic [2:0]        initiator_id,
    // bus resets
    input  wire logic              bus_dev_reset,
    // mode select data stream from the initiator
    input  wire logic              pdata_valid,
    input  wire logic [7:0]        pdata,
    // tape engine events during verify; end-of-medium and write-protect status
    input  wire logic              tape_block_ok,
    input  wire logic              tape_file_mark,
    input  wire logic              end_of_tape_marker,
    input  wire logic              at_end_of_medium,
    input  wire logic              write_protect,
    // buffer engine
    input  wire logic [CNT_W-1:0]  buf_count,
    input  wire logic              buf_block_sent,
    input  wire logic              buf_empty,
    input  wire logic              buf_block_stored,
    output logic                   buf_send_req,
    output logic                   buf_flush_req,
    // completion
    output logic                   cmd_done,
    output logic [7:0]             cmd_status,
    output logic [3:0]             sense_key,
    output logic [CNT_W-1:0]       sense_info,
    output logic                   end_of_medium_flag,
    // current settings
    output logic                   buffered_mode_bit,
    output logic [3:0]             speed_code,
    output logic [7:0]             density_code,
    output logic [23:0]            block_size,
    output logic                   fixed_mode,
    output logic [7:0]             mode_byte2,
    // reservation
    output logic                   reserved,
    output logic [2:0]             res_owner_id,
    output logic                   third_party_bit,
    output logic [2:0]             third_party_target_id
);
    import tscmd_pkg::*;

    function automatic logic speed_ok(input logic [3:0] s);
        speed_ok = (s <= 4'h2);
    endfunction

    function automatic logic dens_ok(input logic [7:0] d);
        dens_ok = (d == 8'h00) || (d == 8'h01) || (d == 8'h02)
               || (d == 8'h03) || (d == 8'h06);
    endfunction

    tscmd_state_t       state;
    logic [CNT_W-1:0]   req_count;
    logic [CNT_W-1:0]   done_count;
    logic [7:0]         plen;
    logic [7:0]         pidx;
    logic [7:0]         p_byte2;
    logic [7:0]         p_dens;
    logic [23:0]        p_blk;
    logic               p_has_desc;
    logic               unit_attn;

    wire logic [CNT_W-1:0] cdb_count = CNT_W'({cmd_byte2, cmd_byte3, cmd_byte4});
    wire logic is_wfm   = cmd_start && cmd_byte0 == `TSCMD_OP_WFM;
    wire logic is_write = cmd_start && cmd_byte0 == `TSCMD_OP_WRITE;
    wire logic is_rs    = cmd_start && cmd_byte0 == `TSCMD_OP_RSENSE;
    wire logic is_res   = cmd_start && cmd_byte0 == `TSCMD_OP_RESERVE;
    wire logic is_rel   = cmd_start && cmd_byte0 == `TSCMD_OP_RELEASE;
    wire logic mine     = !reserved || res_owner_id == initiator_id;
    wire logic last_p   = pdata_valid && (pidx == plen - 8'h01);
    wire logic [23:0] fin_blk = {p_blk[15:0], pdata};
    wire logic blk_ok   = fin_blk == 24'h0
                       || (fin_blk >= `TSCMD_BLK_MIN && fin_blk <= `TSCMD_BLK_MAX);

    assign buf_send_req  = state == TSCMD_RECOVER;
    assign buf_flush_req = state == TSCMD_FLUSH;
    assign mode_byte2 = {write_protect, 2'b00, buffered_mode_bit, speed_code};
    assign fixed_mode = (block_size != 24'h0);

    // command sequencer
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state      <= TSCMD_IDLE;
            req_count  <= '0;
            done_count <= '0;
            plen       <= 8'h00;
            pidx       <= 8'h00;
        end
        else
        begin
            unique case (state)
                TSCMD_IDLE:
                begin
                    done_count <= '0;
                    pidx       <= 8'h00;
                    req_count  <= cdb_count;
                    plen       <= cmd_byte4;
                    if (cmd_start && cmd_byte0 == `TSCMD_OP_VERIFY
                        && cmd_byte1[`TSCMD_BIT_FIXED])
                        state <= (cdb_count == '0) ? TSCMD_DONE : TSCMD_VERIFY;
                    else if (cmd_start && cmd_byte0 == `TSCMD_OP_RECOVER)
                        state <= (cdb_count == '0) ? TSCMD_DONE : TSCMD_RECOVER;
                    else if (cmd_start && cmd_byte0 == `TSCMD_OP_MODESEL)
                        state <= (cmd_byte4 == 8'h00) ? TSCMD_DONE : TSCMD_MSEL;
                    else if (is_wfm && buffered_mode_bit && !at_end_of_medium)
                        state <= TSCMD_FLUSH;
                end
                TSCMD_VERIFY:
                begin
                    if (tape_file_mark || end_of_tape_marker)
                        state <= TSCMD_DONE;
                    else if (tape_block_ok)
                    begin
                        done_count <= done_count + 1'b1;
                        if (done_count + 1'b1 == req_count)
                            state <= TSCMD_DONE;
                    end
                end
                TSCMD_RECOVER:
                begin
                    if (done_count == buf_count && !buf_block_sent)
                        state <= TSCMD_DONE;
                    else if (buf_block_sent)
                    begin
                        done_count <= done_count + 1'b1;
                        if (done_count + 1'b1 == req_count)
                            state <= TSCMD_DONE;
                    end
                end
                TSCMD_MSEL:
                begin
                    if (pdata_valid)
                        pidx <= pidx + 8'h01;
                    if (last_p)
                        state <= TSCMD_DONE;
                end
                TSCMD_FLUSH:
                    if (buf_empty)
                        state <= TSCMD_DONE;
                TSCMD_DONE:
                    state <= TSCMD_IDLE;
            endcase
        end
    end

    // mode select parameter capture
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            p_byte2    <= 8'h00;
            p_dens     <= 8'h00;
            p_blk      <= 24'h0;
            p_has_desc <= 1'b0;
        end
        else if (state == TSCMD_IDLE)
        begin
            p_byte2    <= {3'h0, buffered_mode_bit, speed_code};
            p_dens     <= 8'h00;
            p_blk      <= block_size;
            p_has_desc <= 1'b0;
        end
        else if (state == TSCMD_MSEL && pdata_valid)
        begin
            unique case (pidx)
                8'd2: p_byte2 <= pdata;
                8'd3: p_has_desc <= pdata != 8'h00;
                8'd4: p_dens <= pdata;
                8'd9, 8'd10, 8'd11: p_blk <= {p_blk[15:0], pdata};
                default: ;
            endcase
        end
    end

    // settings commit and completion status
    wire logic p_ok = speed_ok(p_byte2[`TSCMD_SPD_HI:0]) && dens_ok(p_dens)
                   && (!p_has_desc || pidx < 8'd11 || blk_ok);
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            buffered_mode_bit  <= 1'b0;
            speed_code         <= `TSCMD_RST_SPEED;
            density_code       <= `TSCMD_RST_DENS;
            block_size         <= `TSCMD_RST_BLK;
            cmd_done           <= 1'b0;
            cmd_status         <= `TSCMD_ST_GOOD;
            sense_key          <= `TSCMD_SK_NONE;
            sense_info         <= '0;
            end_of_medium_flag <= 1'b0;
        end
        else
        begin
            cmd_done <= 1'b0;
            if (state == TSCMD_MSEL && last_p)
            begin
                cmd_done <= 1'b1;
                if (speed_ok(p_byte2[`TSCMD_SPD_HI:0]) && dens_ok(p_dens)
                    && (!p_has_desc || pidx < 8'd11 || blk_ok))
                begin
                    cmd_status        <= `TSCMD_ST_GOOD;
                    buffered_mode_bit <= p_byte2[`TSCMD_BIT_BM];
                    speed_code        <= p_byte2[`TSCMD_SPD_HI:0];
                    if (p_dens != 8'h00)
                        density_code <= p_dens;
                    if (p_has_desc && pidx >= 8'd11)
                        block_size <= fin_blk;
                end
                else
                begin
                    cmd_status <= `TSCMD_ST_CHECK;
                    sense_key  <= `TSCMD_SK_ILLEGAL;
                end
            end
            else if (state == TSCMD_VERIFY && (tape_file_mark || end_of_tape_marker))
            begin
                cmd_done   <= 1'b1;
                cmd_status <= `TSCMD_ST_CHECK;
                sense_info <= req_count - done_count;
            end
            else if (state == TSCMD_RECOVER && done_count == buf_count && !buf_block_sent)
            begin
                cmd_done           <= 1'b1;
                cmd_status         <= `TSCMD_ST_CHECK;
                end_of_medium_flag <= 1'b1;
                sense_info         <= req_count - done_count;
            end
            else if (state != TSCMD_IDLE && state != TSCMD_MSEL && state != TSCMD_DONE
                     && (state == TSCMD_FLUSH ? buf_empty
                        : ((tape_block_ok && state == TSCMD_VERIFY)
                           || (buf_block_sent && state == TSCMD_RECOVER))
                          && done_count + 1'b1 == req_count))
            begin
                cmd_done   <= 1'b1;
                cmd_status <= `TSCMD_ST_GOOD;
            end
            else if (state == TSCMD_IDLE && cmd_start
                     && ((cdb_count == '0 && (cmd_byte0 == `TSCMD_OP_RECOVER
                          || (cmd_byte0 == `TSCMD_OP_VERIFY && cmd_byte1[`TSCMD_BIT_FIXED])))
                         || (cmd_byte0 == `TSCMD_OP_MODESEL && cmd_byte4 == 8'h00)))
            begin
                cmd_done   <= 1'b1;
                cmd_status <= `TSCMD_ST_GOOD;
            end
            else if (is_write && buffered_mode_bit && buf_block_stored)
            begin
                cmd_done   <= 1'b1;
                cmd_status <= `TSCMD_ST_GOOD;
            end
            else if (is_res)
            begin
                cmd_done   <= 1'b1;
                cmd_status <= mine ? `TSCMD_ST_GOOD : `TSCMD_ST_CONFLICT;
            end
            else if (is_rs)
            begin
                sense_key          <= unit_attn ? `TSCMD_SK_UATTN : `TSCMD_SK_NONE;
                end_of_medium_flag <= 1'b0;
            end
        end
    end

    // reservation bookkeeping
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reserved              <= 1'b0;
            res_owner_id          <= 3'h0;
            third_party_bit       <= 1'b0;
            third_party_target_id <= 3'h0;
        end
        else if (bus_dev_reset)
            reserved <= 1'b0;
        else if (is_res && mine)
        begin
            reserved              <= 1'b1;
            res_owner_id          <= initiator_id;
            third_party_bit       <= cmd_byte1[`TSCMD_BIT_TPTY];
            third_party_target_id <= cmd_byte1[`TSCMD_BIT_TPTY]
                ? cmd_byte1[`TSCMD_TPID_HI:`TSCMD_TPID_LO] : initiator_id;
        end
        else if (is_rel && reserved && res_owner_id == initiator_id)
            reserved <= 1'b0;
    end

    // unit attention after either reset, set wins over the sense clear
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            unit_attn <= 1'b1;
        else if (bus_dev_reset)
            unit_attn <= 1'b1;
        else if (is_rs)
            unit_attn <= 1'b0;
    end

    a_verify_residue: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state == TSCMD_VERIFY && tape_file_mark |=> cmd_done && cmd_status == `TSCMD_ST_CHECK
        && sense_info == $past(req_count) - $past(done_count)) else $error("verify residue wrong");
    a_recover_eom: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state == TSCMD_RECOVER && done_count == buf_count && !buf_block_sent
        |=> end_of_medium_flag && cmd_status == `TSCMD_ST_CHECK) else $error("eom missing");
    a_res_conflict: assert property (@(posedge sys_clk) disable iff (!rst_b)
        is_res && reserved && res_owner_id != initiator_id
        |=> cmd_status == `TSCMD_ST_CONFLICT && $stable(res_owner_id)) else $error("conflict");
    a_bdr_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
        bus_dev_reset |=> !reserved && unit_attn) else $error("bus reset kept hold");
    a_flush_wfm: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state == TSCMD_IDLE && is_wfm && buffered_mode_bit && !at_end_of_medium
        |=> buf_flush_req) else $error("no flush");
    a_msel_reject: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state == TSCMD_MSEL && last_p && !p_ok
        |=> sense_key == `TSCMD_SK_ILLEGAL && $stable(speed_code)) else $error("bad accept");
    a_zero_count: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state == TSCMD_IDLE && cmd_start && cmd_byte0 == `TSCMD_OP_RECOVER && cdb_count == '0
        |=> cmd_done ##1 !buf_send_req) else $error("zero count moved");
    a_third_party: assert property (@(posedge sys_clk) disable iff (!rst_b)
        is_res && mine && !bus_dev_reset && cmd_byte1[`TSCMD_BIT_TPTY]
        |=> third_party_target_id == $past(cmd_byte1[3:1])) else $error("3p id");
endmodule
`default_nettype wire

/* File: sim/tscmd_init_model.sv */
// initiator model: sends command blocks and mode select parameter bytes
// assumes the bench clock; drives only just after rising edges
`timescale 1ns/1ps
`default_nettype none
module tscmd_init_model
(
    // clock
    input  wire logic       sys_clk,
    // command block
    output logic            cmd_start,
    output logic [7:0]      cmd_byte0,
    output logic [7:0]      cmd_byte1,
    output logic [7:0]      cmd_byte2,
    output logic [7:0]      cmd_byte3,
    output logic [7:0]      cmd_byte4,
    output logic [2:0]      initiator_id,
    // parameter stream
    output logic            pdata_valid,
    output logic [7:0]      pdata
);
    initial
    begin
        cmd_start = 1'b0;
        pdata_valid = 1'b0;
        {cmd_byte0, cmd_byte1, cmd_byte2, cmd_byte3, cmd_byte4, pdata} = 48'h5a;
        initiator_id = 3'h0;
    end

    // unqualified bytes show their inverse so stale data never matches
    task send_cmd(input logic [7:0] op, b1, b2, b3, b4, input logic [2:0] id);
        @(posedge sys_clk);
        cmd_start <= 1'b1;
        {cmd_byte0, cmd_byte1} <= {op, b1};
        {cmd_byte2, cmd_byte3, cmd_byte4} <= {b2, b3, b4};
        initiator_id <= id;
        @(posedge sys_clk);
        cmd_start <= 1'b0;
        {cmd_byte0, cmd_byte1, cmd_byte2, cmd_byte3, cmd_byte4} <= ~{op, b1, b2, b3, b4};
        initiator_id <= ~id;
    endtask

    // one parameter byte per strobe, as many as the announced list length
    task send_byte(input logic [7:0] b);
        @(posedge sys_clk);
        pdata_valid <= 1'b1;
        pdata <= b;
        @(posedge sys_clk);
        pdata_valid <= 1'b0;
        pdata <= ~b;
    endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for tscmd_core against a behavioural reference
// assumes tscmd_init_model as initiator; the bench plays tape and buffer engines
`timescale 1ns/1ps
`include "tscmd_cfg.svh"
`default_nettype none
module testbench;
    import tscmd_pkg::*;
    logic            sys_clk = 1'b0;
    logic            rst_b = 1'b0;
    logic            bus_dev_reset, tape_block_ok, tape_file_mark, end_of_tape_marker;
    logic            at_end_of_medium, write_protect, buf_block_sent, buf_empty;
    logic            buf_block_stored, buf_send_req, buf_flush_req, cmd_done;
    logic            end_of_medium_flag, buffered_mode_bit, reserved, third_party_bit;
    logic            fixed_mode;
    logic [23:0]     buf_count, sense_info, block_size;
    logic [7:0]      cmd_status, density_code, mode_byte2;
    logic [3:0]      sense_key, speed_code;
    logic [2:0]      res_owner_id, third_party_target_id;
    wire logic       cmd_start, pdata_valid;
    wire logic [7:0] cmd_byte0, cmd_byte1, cmd_byte2, cmd_byte3, cmd_byte4, pdata;
    wire logic [2:0] initiator_id;
    int              error_cnt = 0;
    int              tests_run = 0;
    int unsigned     rs = 8;
    int              e_bm = 0, e_spd = 0, e_den = 2, e_blk = 0;
    int              e_res = 0, e_own = 0, e_tp = 0, e_tid = 0;
    int              dens[5] = '{0, 1, 2, 3, 6};

    always #10 sys_clk = ~sys_clk;

    tscmd_init_model i_init (.sys_clk(sys_clk), .cmd_start(cmd_start), .cmd_byte0(cmd_byte0),
        .cmd_byte1(cmd_byte1), .cmd_byte2(cmd_byte2), .cmd_byte3(cmd_byte3),
        .cmd_byte4(cmd_byte4), .initiator_id(initiator_id), .pdata_valid(pdata_valid),
        .pdata(pdata));

    tscmd_core #(.CNT_W(24)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_start(cmd_start),
        .cmd_byte0(cmd_byte0), .cmd_byte1(cmd_byte1), .cmd_byte2(cmd_byte2),
        .cmd_byte3(cmd_byte3), .cmd_byte4(cmd_byte4), .initiator_id(initiator_id),
        .bus_dev_reset(bus_dev_reset), .pdata_valid(pdata_valid), .pdata(pdata),
        .tape_block_ok(tape_block_ok), .tape_file_mark(tape_file_mark),
        .end_of_tape_marker(end_of_tape_marker), .at_end_of_medium(at_end_of_medium),
        .write_protect(write_protect), .buf_count(buf_count), .buf_block_sent(buf_block_sent),
        .buf_empty(buf_empty), .buf_block_stored(buf_block_stored),
        .buf_send_req(buf_send_req), .buf_flush_req(buf_flush_req), .cmd_done(cmd_done),
        .cmd_status(cmd_status), .sense_key(sense_key), .sense_info(sense_info),
        .end_of_medium_flag(end_of_medium_flag), .buffered_mode_bit(buffered_mode_bit),
        .speed_code(speed_code), .density_code(density_code), .block_size(block_size),
        .fixed_mode(fixed_mode), .mode_byte2(mode_byte2), .reserved(reserved),
        .res_owner_id(res_owner_id), .third_party_bit(third_party_bit),
        .third_party_target_id(third_party_target_id));

    function int unsigned nxt();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task stop_test;
        $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // one-cycle engine event: 0 block ok, 1 file mark, 2 tape end, 3 block sent
    task ev(input int k);
        @(posedge sys_clk);
        tape_block_ok <= (k == 0);
        tape_file_mark <= (k == 1);
        end_of_tape_marker <= (k == 2);
        buf_block_sent <= (k == 3);
        @(posedge sys_clk);
        {tape_block_ok, tape_file_mark, end_of_tape_marker, buf_block_sent} <= 4'h0;
    endtask

    // bounded wait for completion, then one idle cycle
    task wait_done(input bit need);
        int n;
        n = 0;
        #1;
        while (cmd_done !== 1'b1 && n < 40)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (need && cmd_done !== 1'b1)
        begin
            error_cnt++;
            $display("Error at %0t: no completion", $time);
        end
        $display("command ended at %0t, status %h", $time, cmd_status);
        @(posedge sys_clk);
    endtask

    task verify(input int cnt, input int stop, input int kind);
        int i;
        i_init.send_cmd(`TSCMD_OP_VERIFY, 8'h01, 8'(cnt >> 16), 8'(cnt >> 8), 8'(cnt), 3'h1);
        for (i = 0; i < cnt && i != stop; i++)
            ev(0);
        if (i < cnt)
            ev(kind);
        wait_done(1);
        check(cmd_status, (i < cnt) ? 2 : 0);
        check(buf_send_req, 0);
        if (i < cnt)
            check(sense_info, cnt - i);
    endtask

    task recover(input int req, input int have);
        int i;
        buf_count <= 24'(have);
        buf_empty <= (have == 0);
        i_init.send_cmd(`TSCMD_OP_RECOVER, 8'h01, 8'h00, 8'h00, 8'(req), 3'h1);
        for (i = 0; i < req && i < have; i++)
        begin
            #1;
            check(buf_send_req, 1);
            ev(3);
        end
        buf_empty <= 1'b1;
        wait_done(1);
        check(cmd_status, (req > have) ? 2 : 0);
        check(end_of_medium_flag, req > have);
        if (req > have)
            check(sense_info, req - have);
    endtask

    task sense(input int key);
        i_init.send_cmd(`TSCMD_OP_RSENSE, 8'h00, 8'h00, 8'h00, 8'h12, 3'h1);
        wait_done(0);
        check(sense_key, key);
    endtask

    task msel(input logic [7:0] b2, input int den, input int sz);
        logic [7:0] q[$];
        int ok;
        q = '{8'h00, 8'h00, b2, 8'h08, 8'(den), 8'h00, 8'h00, 8'h00, 8'h00,
              8'(sz >> 16), 8'(sz >> 8), 8'(sz)};
        ok = (b2[3:0] < 3) && (den inside {0, 1, 2, 3, 6}) && (sz == 0 || (sz >= 2 && sz <= 32'h10000));
        i_init.send_cmd(`TSCMD_OP_MODESEL, 8'h00, 8'h00, 8'h00, 8'(q.size()), 3'h1);
        foreach (q[k])
            i_init.send_byte(q[k]);
        wait_done(1);
        if (ok)
        begin
            e_bm = b2[4];
            e_spd = b2[3:0];
            e_den = (den == 0) ? e_den : den;
            e_blk = sz;
        end
        check(cmd_status, ok ? 0 : 2);
        if (!ok)
            check(sense_key, `TSCMD_SK_ILLEGAL);
        check(buffered_mode_bit, e_bm);
        check(speed_code, e_spd);
        check(density_code, e_den);
        check(block_size, e_blk);
        check(fixed_mode, e_blk != 0);
        check(mode_byte2, {write_protect, 2'b00, 1'(e_bm), 4'(e_spd)});
    endtask

    task reserve(input int id, input int tp, input int tid);
        int ok;
        ok = !e_res || e_own == id;
        i_init.send_cmd(`TSCMD_OP_RESERVE, {3'h0, 1'(tp), 3'(tid), 1'b0}, 8'h00, 8'h00, 8'h00,
                        3'(id));
        wait_done(1);
        if (ok)
        begin
            e_res = 1;
            e_own = id;
            e_tp = tp;
            e_tid = tid;
        end
        check(cmd_status, ok ? 0 : 8'h18);
        check(reserved, e_res);
        check(res_owner_id, e_own);
        check(third_party_bit, e_tp);
        if (e_tp)
            check(third_party_target_id, e_tid);
    endtask

    initial
    begin
        {bus_dev_reset, tape_block_ok, tape_file_mark, end_of_tape_marker} = 4'h0;
        {at_end_of_medium, write_protect, buf_block_sent, buf_empty, buf_block_stored} = 5'h0;
        buf_count = 24'h0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        sense(`TSCMD_SK_UATTN);
        verify(3, -1, 0);
        verify(4, 1, 1);
        verify(2, 0, 2);
        verify(1 + nxt() % 8, -1, 0);
        verify(0, -1, 0);
        recover(2, 2);
        recover(0, 3);
        recover(5, 2);
        for (int i = 0; i < 5; i++)
        begin
            write_protect <= i[0];
            msel({3'h0, i[1], 4'(i % 3)}, dens[i], 2 + nxt() % 65535);
        end
        msel(8'h01, 0, 2);
        msel(8'h02, 3, 32'h10000);
        msel(8'h03, 1, 512);
        msel(8'h0f, 1, 512);
        msel(8'h00, 4, 512);
        msel(8'h00, 1, 1);
        msel(8'h00, 1, 32'h10001);
        msel(8'h00, 2, 0);
        msel(8'h11, 2, 512);
        buf_block_stored <= 1'b1;
        i_init.send_cmd(`TSCMD_OP_WRITE, 8'h01, 8'h00, 8'h00, 8'h01, 3'h1);
        buf_block_stored <= 1'b0;
        wait_done(1);
        check(cmd_status, 0);
        at_end_of_medium <= 1'b1;
        i_init.send_cmd(`TSCMD_OP_WFM, 8'h00, 8'h00, 8'h00, 8'h01, 3'h1);
        #1;
        check(buf_flush_req, 0);
        @(posedge sys_clk);
        at_end_of_medium <= 1'b0;
        buf_empty <= 1'b0;
        i_init.send_cmd(`TSCMD_OP_WFM, 8'h00, 8'h00, 8'h00, 8'h01, 3'h1);
        #1;
        check(buf_flush_req, 1);
        @(posedge sys_clk);
        buf_empty <= 1'b1;
        wait_done(1);
        reserve(1, 0, 0);
        reserve(2, 0, 0);
        reserve(1, 1, 5);
        reserve(1, 1, 3);
        reserve(1, 0, 0);
        @(posedge sys_clk);
        bus_dev_reset <= 1'b1;
        @(posedge sys_clk);
        bus_dev_reset <= 1'b0;
        #1;
        e_res = 0;
        check(reserved, 0);
        sense(`TSCMD_SK_UATTN);
        reserve(2, 1, 4);
        rst_b <= 1'b0;
        @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        check(reserved, 0);
        check(density_code, `TSCMD_RST_DENS);
        sense(`TSCMD_SK_UATTN);
        stop_test;
    end

    initial
    begin
        #400000;
        error_cnt++;
        stop_test;
    end
endmodule
`default_nettype wire
